// ### design/sic_sync2.v
module sic_sync2 (
   input wire core_clk,
   input wire rst_n,
   input wire din,
   output reg dout
);
   reg meta_q;
   // First stage is read only by the second stage
   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_q <= 1'b0;
         dout <= 1'b0;
      end
      else
      begin
         meta_q <= din;
         dout <= meta_q;
      end
   end
endmodule // sic_sync2

// ### design/sic_sync_input_conditioner.v
// Summary of operation
// - Internal timing starts at the leading edge of each input sync pulse.
// - Each sync input passes a selectable inverter; one inverts, zero passes.
// - Frame sync invert bit 30: zero rests low, one rests high.
// - Line sync invert bit 29: zero active high default, one active low.
// - Regen select zero forwards corrected line sync unmodified to output.
// - Regen select one regenerates output line sync from timing bits 7:0.
// - Regenerated output polarity follows separate output polarity bit.
// - Lead code 000 no delay; codes 001..111 delay 2..8 pixel clocks.
// - No lead setting gives exactly one pixel clock of delay.
// - Delays count in pixel-clock steps from corrected input rising edge.
// - Lead field bits 7:5 act only when regen select bit 27 set.
// - Trailing at or before leading edge produces no output pulse.
// - Frame sync input polarity never affects output frame polarity bit 23.
// - Timing register resets to all zeros.
// - Trail field delays trailing edge by its value; 00000 gives no pulse.
// - Edge fields apply only when regen select bit is one.
`include "sic_defines.vh"
module sic_sync_input_conditioner #(
   parameter CNT_W = 6
) (
   input wire core_clk,
   input wire rst_n,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [11:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   output reg wb_err_o,
   input wire pixel_clock,
   input wire frame_sync_in,
   input wire line_sync_in,
   output reg line_sync_out,
   output reg frame_sync_start,
   output reg line_sync_start,
   output reg frame_out_invert
);
   reg [31:0] timing_q;
   reg [31:0] outctl_q;
   reg [31:0] wmask_d;
   reg [31:0] rdata_d;
   reg hit_d;
   wire pix_s;
   wire vs_s;
   wire hs_s;
   reg pix_q;
   reg vs_q;
   reg hs_q;
   reg [CNT_W-1:0] cnt_q;
   reg run_q;
   reg pulse_q;
   reg [CNT_W-1:0] lead_d;
   wire [CNT_W-1:0] trail_w;
   wire vsync_in_invert;
   wire hsync_in_invert;
   wire line_sync_regen_sel;
   wire vs_corr;
   wire hs_corr;
   wire pix_rise;
   wire hs_rise;
   wire vs_rise;
   wire req;
   wire wr_timing;
   wire wr_outctl;
   wire lead_reached;
   wire trail_done;
   wire pulse_d;

   integer i;

   assign vsync_in_invert = timing_q[`SIC_BIT_VS_INV];
   assign hsync_in_invert = timing_q[`SIC_BIT_HS_INV];
   assign line_sync_regen_sel = timing_q[`SIC_BIT_REGEN];
   assign trail_w = {{(CNT_W-5){1'b0}}, timing_q[`SIC_TRAIL_HI:`SIC_TRAIL_LO]};

   sic_sync2 u_sync_pix (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .din(pixel_clock),
      .dout(pix_s)
   );
   sic_sync2 u_sync_vs (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .din(frame_sync_in),
      .dout(vs_s)
   );
   sic_sync2 u_sync_hs (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .din(line_sync_in),
      .dout(hs_s)
   );

   // Flipping an invert bit while its input rests looks like an edge; set it first
   // Selectable inverters bring each leading edge up as a rising edge
   assign vs_corr = vs_s ^ vsync_in_invert;
   assign hs_corr = hs_s ^ hsync_in_invert;

   // Corrected sync edges are detected on pixel clock rising edges only
   assign pix_rise = pix_s & ~pix_q;
   assign hs_rise = pix_rise & hs_corr & ~hs_q;
   assign vs_rise = pix_rise & vs_corr & ~vs_q;

   always @*
   begin
      // Code 000 is no delay, then 2..8; one clock is not reachable
      case (timing_q[`SIC_LEAD_HI:`SIC_LEAD_LO])
         3'h0: lead_d = {CNT_W{1'b0}};
         3'h1: lead_d = {{(CNT_W-4){1'b0}}, 4'h2};
         3'h2: lead_d = {{(CNT_W-4){1'b0}}, 4'h3};
         3'h3: lead_d = {{(CNT_W-4){1'b0}}, 4'h4};
         3'h4: lead_d = {{(CNT_W-4){1'b0}}, 4'h5};
         3'h5: lead_d = {{(CNT_W-4){1'b0}}, 4'h6};
         3'h6: lead_d = {{(CNT_W-4){1'b0}}, 4'h7};
         3'h7: lead_d = {{(CNT_W-4){1'b0}}, 4'h8};
         default: lead_d = {CNT_W{1'b0}};
      endcase
   end

   assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
   assign wr_timing = req & hit_d & wb_we_i & (wb_adr_i == `SIC_ADDR_TIMING);
   assign wr_outctl = req & hit_d & wb_we_i & (wb_adr_i == `SIC_ADDR_OUTCTL);

   always @*
   begin
      wmask_d = 32'h00000000;
      for (i = 0; i < 4; i = i + 1)
      begin
         wmask_d[i*8 +: 8] = {8{wb_sel_i[i]}};
      end
      hit_d = 1'b1;
      case (wb_adr_i)
         `SIC_ADDR_TIMING: rdata_d = timing_q;
         `SIC_ADDR_OUTCTL: rdata_d = outctl_q;
         `SIC_ADDR_STATUS: rdata_d = {29'h00000000, run_q, hs_corr, vs_corr};
         default:
         begin
            rdata_d = 32'h00000000;
            hit_d = 1'b0;
         end
      endcase
   end

   // A held request is not taken again while its answer is out
   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wb_dat_o <= 32'h00000000;
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
      end
      else
      begin
         wb_ack_o <= req & hit_d;
         wb_err_o <= req & ~hit_d;
         if (req & hit_d)
         begin
            wb_dat_o <= rdata_d;
         end
         else
         begin
            wb_dat_o <= 32'h00000000;
         end
      end
   end

   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         timing_q <= `SIC_TIMING_RST;
      end
      else if (wr_timing)
      begin
         // Spare bits are masked off so they always read back as zero
         timing_q <= ((timing_q & ~wmask_d) | (wb_dat_i & wmask_d)) & `SIC_TIMING_MASK;
      end
   end

   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         outctl_q <= `SIC_OUTCTL_RST;
      end
      else if (wr_outctl)
      begin
         outctl_q <= ((outctl_q & ~wmask_d) | (wb_dat_i & wmask_d)) & `SIC_OUTCTL_MASK;
      end
   end

   // Previous synced pixel clock level, for finding its rising edge
   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pix_q <= 1'b0;
      end
      else
      begin
         pix_q <= pix_s;
      end
   end

   // Corrected sync history moves only at pixel clock rising edges
   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         vs_q <= 1'b0;
         hs_q <= 1'b0;
      end
      else if (pix_rise)
      begin
         vs_q <= vs_corr;
         hs_q <= hs_corr;
      end
   end

   // Start pulses last one core cycle, whatever the pixel clock period
   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         frame_sync_start <= 1'b0;
         line_sync_start <= 1'b0;
      end
      else
      begin
         frame_sync_start <= vs_rise;
         line_sync_start <= hs_rise;
      end
   end

   // Output frame polarity comes only from its own bit
   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         frame_out_invert <= 1'b0;
      end
      else
      begin
         frame_out_invert <= outctl_q[`SIC_BIT_VS_OUT_POL];
      end
   end

   assign lead_reached = cnt_q >= lead_d;
   assign trail_done = cnt_q >= trail_w;
   // Trail 0 or a trail at or before the lead never opens the window
   assign pulse_d = run_q & lead_reached & ~trail_done;

   // Pixel counter from the corrected leading edge; it stops past the trailing edge
   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_q <= {CNT_W{1'b0}};
         run_q <= 1'b0;
      end
      else if (hs_rise)
      begin
         cnt_q <= {CNT_W{1'b0}};
         run_q <= 1'b1;
      end
      else if (pix_rise && run_q)
      begin
         cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
         if (trail_done)
         begin
            run_q <= 1'b0;
         end
      end
   end

   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pulse_q <= 1'b0;
         line_sync_out <= 1'b0;
      end
      else
      begin
         pulse_q <= pulse_d;
         if (line_sync_regen_sel)
         begin
            line_sync_out <= pulse_q ^ outctl_q[`SIC_BIT_HS_OUT_POL];
         end
         else
         begin
            // Pass-through applies no output polarity
            line_sync_out <= hs_corr;
         end
      end
   end
endmodule // sic_sync_input_conditioner

// ### pkg/sic_defines.vh
`ifndef SIC_DEFINES_VH
`define SIC_DEFINES_VH
`define SIC_ADDR_TIMING 12'h400
`define SIC_ADDR_OUTCTL 12'h404
`define SIC_ADDR_STATUS 12'h408
`define SIC_TIMING_RST 32'h00000000
`define SIC_OUTCTL_RST 32'h00000000
`define SIC_TIMING_MASK 32'h680000FF
`define SIC_OUTCTL_MASK 32'h00C00000
`define SIC_BIT_VS_INV 30
`define SIC_BIT_HS_INV 29
`define SIC_BIT_REGEN 27
`define SIC_LEAD_HI 7
`define SIC_LEAD_LO 5
`define SIC_TRAIL_HI 4
`define SIC_TRAIL_LO 0
`define SIC_BIT_HS_OUT_POL 22
`define SIC_BIT_VS_OUT_POL 23
`define SIC_SYNC_STAGES 2
`endif

// ### testbench/sic_checker.sv
`include "sic_defines.vh"
module sic_checker (
   input wire core_clk,
   input wire rst_n,
   input wire wb_we_i,
   input wire [11:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   input wire [31:0] wb_dat_o,
   input wire wb_ack_o,
   input wire wb_err_o,
   input wire line_sync_start,
   input wire frame_sync_start,
   input wire frame_out_invert
);
timeunit 1ns;
timeprecision 1ns;
default clocking cb @(posedge core_clk);
endclocking
default disable iff (!rst_n);
AST_ACK: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
AST_ONE: assert property (!(wb_ack_o && wb_err_o)) else $error("ack with err");
AST_DAT: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data idle");
AST_RO: assert property (wb_ack_o && !wb_we_i && wb_adr_i == `SIC_ADDR_TIMING
   |-> (wb_dat_o & ~`SIC_TIMING_MASK) == 32'h0) else $error("spare bits");
AST_ERR: assert property (wb_err_o |-> wb_adr_i != `SIC_ADDR_TIMING
   && wb_adr_i != `SIC_ADDR_OUTCTL && wb_adr_i != `SIC_ADDR_STATUS) else $error("err");
AST_LS: assert property (line_sync_start |=> !line_sync_start) else $error("ls");
AST_FS: assert property (frame_sync_start |=> !frame_sync_start) else $error("fs");
AST_POL: assert property (wb_ack_o && wb_we_i && wb_adr_i == `SIC_ADDR_OUTCTL &&
   wb_sel_i[2] |=> frame_out_invert == $past(wb_dat_i[23])) else $error("pol");
endmodule // sic_checker
bind sic_sync_input_conditioner sic_checker chk (.core_clk, .rst_n, .wb_we_i, .wb_adr_i,
   .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .line_sync_start,
   .frame_sync_start, .frame_out_invert);

// ### testbench/sic_src_model.sv
module sic_src_model (
   input wire hs_inv,
   input wire vs_inv,
   input wire fire,
   output logic pixel_clock,
   output wire line_sync_in,
   output wire frame_sync_in
);
timeunit 1ns;
timeprecision 1ns;
logic act = 1'h0;
// Free-running dot clock, phase unrelated to core_clk
initial
begin
   pixel_clock = 1'h0;
   #3;
   forever #40 pixel_clock = ~pixel_clock;
end
// Source launches syncs on falling dot clock edges
always @(posedge fire)
begin
   repeat (3) @(negedge pixel_clock);
   act = 1'h1;
   repeat (4) @(negedge pixel_clock);
   act = 1'h0;
end
assign line_sync_in = act ^ hs_inv;
assign frame_sync_in = act ^ vs_inv;
endmodule // sic_src_model

// ### testbench/tb.sv
`include "sic_defines.vh"
module tb;
timeunit 1ns;
timeprecision 1ns;
logic core_clk = 1'h0, rst_n = 1'h0, wb_cyc_i = 1'h0, wb_we_i = 1'h0, fire = 1'h0, e;
logic [11:0] wb_adr_i = 12'h000;
logic [3:0] wb_sel_i = 4'hF;
logic [31:0] wb_dat_i = 32'h0, ctl = 32'h0, rd;
wire [31:0] wb_dat_o;
wire wb_ack_o, wb_err_o, pixel_clock, frame_sync_in, line_sync_in, line_sync_out;
wire frame_sync_start, line_sync_start, frame_out_invert;
int err_total = 0, checks = 0, d, d0, w, st, l;
sic_sync_input_conditioner uut (.core_clk, .rst_n, .wb_cyc_i, .wb_stb_i(wb_cyc_i),
   .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o,
   .pixel_clock, .frame_sync_in, .line_sync_in, .line_sync_out, .frame_sync_start,
   .line_sync_start, .frame_out_invert);
sic_src_model src (.hs_inv(ctl[29]), .vs_inv(ctl[30]), .fire, .pixel_clock, .line_sync_in,
   .frame_sync_in);
initial forever #5 core_clk = ~core_clk;
initial
begin
   repeat (30000) @(posedge core_clk);
   err_total++;
   results();
end
task automatic results();
   if (err_total == 0 && checks > 0)
      $display("TEST PASSED");
   else
      $display("TEST FAILED");
   $finish;
endtask
task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
   checks++;
   if (got !== exp)
   begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, exp, got);
   end
endtask
task automatic bus(input logic we, input logic [11:0] a, input logic [31:0] dat);
   @(posedge core_clk);
   wb_cyc_i <= 1'h1;
   wb_we_i <= we;
   wb_adr_i <= a;
   wb_dat_i <= dat;
   do @(posedge core_clk); while (wb_ack_o !== 1'h1 && wb_err_o !== 1'h1);
   rd = wb_dat_o;
   e = wb_err_o;
   wb_cyc_i <= 1'h0;
endtask
// Settle first: a polarity change alone makes a stray edge
task automatic shot(input logic idle);
   int t0;
   t0 = -1;
   d = -1;
   w = 0;
   st = 0;
   repeat (200) @(posedge core_clk);
   fire <= 1'h1;
   for (int n = 0; n < 300; n++)
   begin
      @(negedge core_clk);
      if (t0 < 0 && line_sync_in !== ctl[29]) t0 = n;
      st += (frame_sync_start === 1'h1) + (line_sync_start === 1'h1);
      if (line_sync_out !== idle)
      begin
         w++;
         if (d < 0) d = n - t0;
      end
   end
   @(posedge core_clk);
   fire <= 1'h0;
endtask
initial
begin
   repeat (12) @(posedge core_clk);
   rst_n <= 1'h1;
   bus(1'h0, `SIC_ADDR_TIMING, 32'h0);
   cmp("rst", `SIC_TIMING_RST, rd);
   wb_sel_i <= 4'h1;
   bus(1'h1, `SIC_ADDR_TIMING, 32'hFFFFFFFF);
   wb_sel_i <= 4'hF;
   bus(1'h0, `SIC_ADDR_TIMING, 32'h0);
   cmp("sel", 32'h000000FF, rd);
   bus(1'h1, 12'h010, 32'h0);
   cmp("unmapped", 32'h1, e);
   bus(1'h1, `SIC_ADDR_TIMING, 32'hFFFFFFFF);
   bus(1'h0, `SIC_ADDR_TIMING, 32'h0);
   cmp("rw", `SIC_TIMING_MASK, rd);
   repeat (20) @(posedge core_clk);
   bus(1'h0, `SIC_ADDR_STATUS, 32'h0);
   cmp("status", 32'h7, rd);
   ctl = 32'h600000E3;
   bus(1'h1, `SIC_ADDR_TIMING, ctl);
   shot(1'h0);
   cmp("pass", 32'h20, w);
   cmp("starts", 32'h2, st);
   cmp("fpol", 32'h0, frame_out_invert);
   for (int c = 0; c < 10; c++)
   begin
      ctl = c < 8 ? 32'h0800000A | (c << 5) : (c == 8 ? 32'h080000E5 : 32'h08000000);
      bus(1'h1, `SIC_ADDR_TIMING, ctl);
      shot(1'h0);
      if (c == 0) d0 = d;
      l = (c == 0) ? 0 : c + 1;
      cmp("width", c < 8 ? (10 - l) * 8 : 0, w);
      if (c < 8) cmp("lead", l * 8, d - d0);
   end
   bus(1'h1, `SIC_ADDR_OUTCTL, 32'h00C00000);
   ctl = 32'h4800000A;
   bus(1'h1, `SIC_ADDR_TIMING, ctl);
   shot(1'h1);
   cmp("inv", 32'h50, w);
   cmp("fpol", 32'h1, frame_out_invert);
   results();
end
endmodule // tb
